// *** spbs_device.sv ***
// spbs_device: burst-of-four memory with a read-only port and a write-only port
// assumes the controller on the link runs on core_clk and alternates kRise each edge
`timescale 1ns/1ps
// Function
// - separate read port and write port
// - every access is four sequential words
// - strap high: read latency one and half
// - strap low: legacy one cycle latency
// - accesses begin only at K rise
// - selects and lanes registered before use
// - read data launched from output registers
// - read select low stores read address
// - lowest word first, one per beat
// - back-to-back read request is dropped
// - controller reads at most every other K
// - paced reads give gapless read data
// - finish bursts, then float after C rise
// - write select low presents write address
// - write words captured per beat, masked lanes
// - four words written at latched address
// - back-to-back write request is dropped
// - paced writes take one word per beat
// - deselected write port finishes, then ignores
// - storage is four word-lane arrays
// - disabled byte lane keeps stored byte
// - single clock mode fixed at reset
// - read after write forwards newest data, except one lane goes stale if another write follows at the next K
// - both selected: read first, then alternate
module spbs_device #(
  parameter int ADDR_W = spbs_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  spbs_if.dev link,
  input wire logic dllOffStrapN,
  output logic singleClockMode
);
  localparam int DW = spbs_pkg::DATA_W;
  localparam int BW = spbs_pkg::BYTE_W;
  localparam int NB = spbs_pkg::BYTES;
  localparam int NL = spbs_pkg::BEATS;

  // ----------------------------------------
  // input registers
  // ----------------------------------------
  logic kRise_reg;
  logic rdSelN_reg;
  logic wrSelN_reg;
  logic [NB-1:0] bwN_reg;
  logic [ADDR_W-1:0] addrIn_reg;
  logic [DW-1:0] wrDataIn_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      kRise_reg <= 1'b0;
      rdSelN_reg <= 1'b1;
      wrSelN_reg <= 1'b1;
      bwN_reg <= '1;
      addrIn_reg <= '0;
      wrDataIn_reg <= '0;
    end else begin
      kRise_reg <= link.kRise;
      rdSelN_reg <= link.readPortSelectN;
      wrSelN_reg <= link.writePortSelectN;
      bwN_reg <= link.byteLaneEnableN;
      addrIn_reg <= link.addr;
      wrDataIn_reg <= link.wrData;
    end
  end

  // ----------------------------------------
  // straps
  // ----------------------------------------
  // the dll strap is a board pin, so it is synchronised before use
  logic [2:0] dllSync_reg;
  logic dllOn_reg;
  logic strapDone_reg;
  logic singleClk_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dllSync_reg <= 3'h7;
      dllOn_reg <= 1'b1;
    end else begin
      dllSync_reg <= {dllSync_reg[1:0], dllOffStrapN};
      if (dllSync_reg[1] == dllSync_reg[2]) begin
        dllOn_reg <= dllSync_reg[2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strapDone_reg <= 1'b0;
      singleClk_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strapDone_reg <= 1'b1;
      singleClk_reg <= link.outClkStrapHigh;
    end
  end

  assign singleClockMode = singleClk_reg;

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  logic prevRead_reg;
  logic prevWrite_reg;
  logic readWant;
  logic writeWant;
  logic readGo;
  logic writeGo;

  always_comb begin
    readWant = kRise_reg && !rdSelN_reg;
    writeWant = kRise_reg && !wrSelN_reg;
    readGo = readWant && !prevRead_reg;
    writeGo = writeWant && !prevWrite_reg && !readGo;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevRead_reg <= 1'b0;
      prevWrite_reg <= 1'b0;
    end else if (kRise_reg) begin
      prevRead_reg <= readGo;
      prevWrite_reg <= writeGo;
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // one array per word lane, so a burst is one address in all four
  logic [DW-1:0] mem [NL][2**ADDR_W];

  // ----------------------------------------
  // write collection
  // ----------------------------------------
  logic [ADDR_W-1:0] wrAddr_reg;
  logic [2:0] wrCnt_reg;
  logic [DW-1:0] wrBuf_reg [NL];
  logic [NB-1:0] wrKeepN_reg [NL];
  logic [NL-1:0] wrHave_reg;
  logic [1:0] wrIdx;
  logic commit_reg;
  logic [ADDR_W-1:0] commitAddr_reg;
  assign wrIdx = 2'(3'h4 - wrCnt_reg);
  // paced requests overlap the last beats, so the commit keeps its own address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrAddr_reg <= '0;
      wrCnt_reg <= 3'h0;
      wrHave_reg <= '0;
      commit_reg <= 1'b0;
      commitAddr_reg <= '0;
      for (int l = 0; l < NL; l++) begin
        wrBuf_reg[l] <= '0;
        wrKeepN_reg[l] <= '1;
      end
    end else begin
      commit_reg <= (wrCnt_reg == spbs_pkg::WR_COMMIT + 3'h1);
      commitAddr_reg <= wrAddr_reg;
      if (writeGo) begin
        wrAddr_reg <= addrIn_reg;
        wrCnt_reg <= spbs_pkg::WR_START;
        wrHave_reg <= '0;
      end else if (wrCnt_reg != 3'h0) begin
        wrCnt_reg <= wrCnt_reg - 3'h1;
      end
      if (wrCnt_reg != 3'h0 && wrCnt_reg <= 3'h4) begin
        wrBuf_reg[wrIdx] <= wrDataIn_reg;
        wrKeepN_reg[wrIdx] <= bwN_reg;
        wrHave_reg[wrIdx] <= !writeGo;
      end
    end
  end
  // the last word goes straight from the input register into the array
  always_ff @(posedge core_clk) begin
    if (!rst && commit_reg) begin
      for (int l = 0; l < NL; l++) begin
        for (int b = 0; b < NB; b++) begin
          if (l == NL - 1) begin
            if (!bwN_reg[b]) begin
              mem[l][commitAddr_reg][b*BW +: BW] <= wrDataIn_reg[b*BW +: BW];
            end
          end else if (!wrKeepN_reg[l][b]) begin
            mem[l][commitAddr_reg][b*BW +: BW] <= wrBuf_reg[l][b*BW +: BW];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  function automatic logic [DW-1:0] fetch(input logic [1:0] lane,
                                          input logic [ADDR_W-1:0] a);
    logic [DW-1:0] v;
    v = mem[lane][a];
    if (wrCnt_reg != 3'h0 && wrAddr_reg == a && wrHave_reg[lane]) begin
      for (int b = 0; b < NB; b++) begin
        if (!wrKeepN_reg[lane][b]) begin
          v[b*BW +: BW] = wrBuf_reg[lane][b*BW +: BW];
        end
      end
    end
    return v;
  endfunction : fetch

  logic [1:0] rdPipeV_reg;
  logic [ADDR_W-1:0] rdPipeA_reg [2];
  logic launch;
  logic [ADDR_W-1:0] launchAddr;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPipeV_reg <= 2'h0;
      rdPipeA_reg[0] <= '0;
      rdPipeA_reg[1] <= '0;
    end else begin
      rdPipeV_reg <= {rdPipeV_reg[0], readGo};
      rdPipeA_reg[0] <= addrIn_reg;
      rdPipeA_reg[1] <= rdPipeA_reg[0];
    end
  end

  // latency picks the tap: two beats legacy, three beats with the dll
  always_comb begin
    if (dllOn_reg) begin
      launch = rdPipeV_reg[spbs_pkg::LAT_DLL_BEATS - 2];
      launchAddr = rdPipeA_reg[spbs_pkg::LAT_DLL_BEATS - 2];
    end else begin
      launch = rdPipeV_reg[spbs_pkg::LAT_LEGACY_BEATS - 2];
      launchAddr = rdPipeA_reg[spbs_pkg::LAT_LEGACY_BEATS - 2];
    end
  end

  logic [ADDR_W-1:0] rdAddr_reg;
  logic [1:0] rdLane_reg;
  logic [2:0] rdLeft_reg;
  logic [DW-1:0] rdData_reg;
  logic rdOe_reg;
  logic echo_reg;

  // a new burst lands exactly as the previous one empties, so no gap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdAddr_reg <= '0;
      rdLane_reg <= 2'h0;
      rdLeft_reg <= 3'h0;
      rdData_reg <= '0;
    end else if (launch) begin
      rdAddr_reg <= launchAddr;
      rdData_reg <= fetch(2'h0, launchAddr);
      rdLane_reg <= 2'h1;
      rdLeft_reg <= spbs_pkg::RD_LEFT_START;
    end else if (rdLeft_reg != 3'h0) begin
      rdData_reg <= fetch(rdLane_reg, rdAddr_reg);
      rdLane_reg <= rdLane_reg + 2'h1;
      rdLeft_reg <= rdLeft_reg - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdOe_reg <= 1'b0;
    end else if (launch) begin
      rdOe_reg <= 1'b1;
    end else if (rdLeft_reg == 3'h0 && link.kRise) begin
      rdOe_reg <= 1'b0;
    end
  end

  // output clocks are modelled one edge behind the input pair
  always_ff @(posedge core_clk) begin
    if (rst) begin
      echo_reg <= 1'b0;
    end else begin
      echo_reg <= link.kRise;
    end
  end

  assign link.rdData = rdData_reg;
  assign link.rdDataOe = rdOe_reg;
  assign link.echoTimingOut = echo_reg;
endmodule : spbs_device

// *** spbs_host.sv ***
// spbs_host: memory controller end of the link, with a read-data FIFO
// assumes the device shares core_clk and reads the kRise phase this end makes
`timescale 1ns/1ps
module spbs_fifo #(
  parameter int WIDTH = spbs_pkg::DATA_W,
  parameter int DEPTH = spbs_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (count_reg != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdPtr_reg];
  assign level = count_reg;

  always_ff @(posedge core_clk) begin
    if (push) begin
      store[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule : spbs_fifo

module spbs_host #(
  parameter int ADDR_W = spbs_pkg::ADDR_W,
  parameter int FIFO_DEPTH = spbs_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  spbs_if.host link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [spbs_pkg::BURST_W-1:0] cmdWrData,
  input wire logic [spbs_pkg::MASK_W-1:0] cmdByteEnN,
  input wire logic dllOffStrapN,
  input wire logic singleClock,
  output logic rdValid,
  input wire logic rdReady,
  output logic [spbs_pkg::DATA_W-1:0] rdWord
);
  localparam int DW = spbs_pkg::DATA_W;
  localparam int NB = spbs_pkg::BYTES;
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------
  // phase and straps
  // ----------------------------------------
  logic kPhase_reg;
  logic [2:0] dllSync_reg;
  logic dllOn_reg;
  logic strap_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      kPhase_reg <= 1'b0;
      dllSync_reg <= 3'h7;
      dllOn_reg <= 1'b1;
    end else begin
      kPhase_reg <= !kPhase_reg;
      dllSync_reg <= {dllSync_reg[1:0], dllOffStrapN};
      if (dllSync_reg[1] == dllSync_reg[2]) begin
        dllOn_reg <= dllSync_reg[2];
      end
    end
  end

  // the strap tracks its pin through reset, so the device sees it at release
  always_ff @(posedge core_clk) begin
    strap_reg <= singleClock;
  end

  // ----------------------------------------
  // issue
  // ----------------------------------------
  logic [LW-1:0] fifoLevel;
  logic fifoInReady;
  logic [4:0] inflight_reg;
  logic lastRead_reg;
  logic lastWrite_reg;
  logic slot;
  logic room;
  logic issueRead;
  logic issueWrite;
  logic push;

  // credit counts words still in flight so the FIFO can never overflow
  always_comb begin
    slot = !kPhase_reg;
    room = (int'(fifoLevel) + int'(inflight_reg) + spbs_pkg::BEATS) <= FIFO_DEPTH;
    issueRead = slot && cmdValid && !cmdWrite && !lastRead_reg && room && fifoInReady;
    issueWrite = slot && cmdValid && cmdWrite && !lastWrite_reg;
    cmdReady = issueRead || issueWrite;
  end

  logic rpsN_reg;
  logic wpsN_reg;
  logic [ADDR_W-1:0] addr_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rpsN_reg <= 1'b1;
      wpsN_reg <= 1'b1;
      addr_reg <= '0;
      lastRead_reg <= 1'b0;
      lastWrite_reg <= 1'b0;
    end else begin
      rpsN_reg <= !issueRead;
      wpsN_reg <= !issueWrite;
      if (slot) begin
        addr_reg <= cmdAddr;
        lastRead_reg <= issueRead;
        lastWrite_reg <= issueWrite;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      inflight_reg <= 5'h00;
    end else begin
      inflight_reg <= inflight_reg + (issueRead ? 5'h04 : 5'h00) - (push ? 5'h01 : 5'h00);
    end
  end

  // ----------------------------------------
  // write data beats
  // ----------------------------------------
  logic [spbs_pkg::BURST_W-1:0] wrHold_reg;
  logic [spbs_pkg::MASK_W-1:0] mHold_reg;
  logic [spbs_pkg::BURST_W-1:0] pendData_reg;
  logic [spbs_pkg::MASK_W-1:0] pendMask_reg;
  logic [1:0] wrPend_reg;
  logic [1:0] wrLeft_reg;
  logic [DW-1:0] wrData_reg;
  logic [NB-1:0] bwN_reg;

  // data leaves two edges after the request, one word per beat
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrHold_reg <= '0;
      mHold_reg <= '1;
      pendData_reg <= '0;
      pendMask_reg <= '1;
      wrPend_reg <= 2'h0;
      wrLeft_reg <= 2'h0;
      wrData_reg <= '0;
      bwN_reg <= '1;
    end else begin
      // a paced command arrives while the last words still shift out
      if (issueWrite) begin
        pendData_reg <= cmdWrData;
        pendMask_reg <= cmdByteEnN;
        wrPend_reg <= spbs_pkg::HOST_WR_DELAY;
      end else if (wrPend_reg != 2'h0) begin
        wrPend_reg <= wrPend_reg - 2'h1;
      end
      if (wrPend_reg == spbs_pkg::HOST_WR_LOAD) begin
        wrData_reg <= pendData_reg[DW-1:0];
        bwN_reg <= pendMask_reg[NB-1:0];
        wrHold_reg <= pendData_reg >> DW;
        mHold_reg <= {{NB{1'b1}}, pendMask_reg[spbs_pkg::MASK_W-1:NB]};
        wrLeft_reg <= 2'h3;
      end else if (wrLeft_reg != 2'h0) begin
        wrData_reg <= wrHold_reg[DW-1:0];
        bwN_reg <= mHold_reg[NB-1:0];
        wrHold_reg <= wrHold_reg >> DW;
        mHold_reg <= {{NB{1'b1}}, mHold_reg[spbs_pkg::MASK_W-1:NB]};
        wrLeft_reg <= wrLeft_reg - 2'h1;
      end else begin
        bwN_reg <= '1;
      end
    end
  end

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  logic [spbs_pkg::CAP_W-1:0] capWin_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      capWin_reg <= '0;
    end else begin
      capWin_reg <= {capWin_reg[spbs_pkg::CAP_W-2:0], issueRead};
    end
  end

  always_comb begin
    if (dllOn_reg) begin
      push = |capWin_reg[spbs_pkg::LAT_DLL_BEATS + 4 -: 4];
    end else begin
      push = |capWin_reg[spbs_pkg::LAT_LEGACY_BEATS + 4 -: 4];
    end
  end

  spbs_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_rdFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(push),
    .inReady(fifoInReady),
    .inData(link.rdData),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdWord),
    .level(fifoLevel)
  );

  assign link.kRise = kPhase_reg;
  assign link.readPortSelectN = rpsN_reg;
  assign link.writePortSelectN = wpsN_reg;
  assign link.addr = addr_reg;
  assign link.wrData = wrData_reg;
  assign link.byteLaneEnableN = bwN_reg;
  assign link.outClkStrapHigh = strap_reg;
endmodule : spbs_host

// *** spbs_if.sv ***
// spbs_if: pins between the memory controller and the memory device
// assumes both ends run on the same core_clk; the controller makes kRise
`timescale 1ns/1ps
interface spbs_if #(
  parameter int ADDR_W = spbs_pkg::ADDR_W
);
  logic kRise;
  logic readPortSelectN;
  logic writePortSelectN;
  logic [ADDR_W-1:0] addr;
  logic [spbs_pkg::DATA_W-1:0] wrData;
  logic [spbs_pkg::BYTES-1:0] byteLaneEnableN;
  logic outClkStrapHigh;
  logic [spbs_pkg::DATA_W-1:0] rdData;
  logic rdDataOe;
  logic echoTimingOut;

  modport dev (
    input kRise, readPortSelectN, writePortSelectN, addr, wrData, byteLaneEnableN,
    input outClkStrapHigh,
    output rdData, rdDataOe, echoTimingOut
  );
  modport host (
    output kRise, readPortSelectN, writePortSelectN, addr, wrData, byteLaneEnableN,
    output outClkStrapHigh,
    input rdData, rdDataOe, echoTimingOut
  );
endinterface : spbs_if

// *** spbs_pkg.sv ***
// spbs_pkg: shared constants of the split-port burst-of-four memory link
// assumes one core clock; one link beat per core_clk edge, K and K# rises alternate
package spbs_pkg;
  // ----------------------------------------
  // data shape
  // ----------------------------------------
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int BYTES = 2;
  localparam int BEATS = 4;
  localparam int ADDR_W = 19;
  localparam int BURST_W = BEATS * DATA_W;
  localparam int MASK_W = BEATS * BYTES;
  // ----------------------------------------
  // timing in link beats (half input-clock cycles)
  // ----------------------------------------
  localparam int LAT_DLL_BEATS = 3;
  localparam int LAT_LEGACY_BEATS = 2;
  localparam logic [2:0] WR_START = 3'h5;
  localparam logic [2:0] WR_COMMIT = 3'h1;
  localparam logic [2:0] RD_LEFT_START = 3'h3;
  localparam logic [1:0] HOST_WR_DELAY = 2'h2;
  localparam logic [1:0] HOST_WR_LOAD = 2'h1;
  localparam int CAP_W = 8;
  localparam int FIFO_DEPTH = 16;
endpackage : spbs_pkg

// *** spbs_props.sv ***
// spbs_props: concurrent checks on the link between host and device
// assumes one core_clk; instantiated beside the interface, no bind
`timescale 1ns/1ps
module spbs_props #(
  parameter int ADDR_W = spbs_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic kRise,
  input wire logic readPortSelectN,
  input wire logic writePortSelectN,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [spbs_pkg::DATA_W-1:0] wrData,
  input wire logic [spbs_pkg::BYTES-1:0] byteLaneEnableN,
  input wire logic outClkStrapHigh,
  input wire logic [spbs_pkg::DATA_W-1:0] rdData,
  input wire logic rdDataOe,
  input wire logic echoTimingOut,
  input wire logic dllOffStrapN
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ------
  // accepted requests, tracked beside the link
  // ------
  logic rdTaken_reg;
  logic wrTaken_reg;
  logic [7:0] rdPipe_reg;
  logic [5:0] wrPipe_reg;
  logic rdGo;
  logic wrGo;
  assign rdGo = kRise && !readPortSelectN && !rdTaken_reg;
  assign wrGo = kRise && !writePortSelectN && !wrTaken_reg && !rdGo;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdTaken_reg <= 1'b0;
      wrTaken_reg <= 1'b0;
    end else if (kRise) begin
      rdTaken_reg <= rdGo;
      wrTaken_reg <= wrGo;
    end
  end
  // shift chains, so paced bursts that overlap are still seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPipe_reg <= 8'h00;
      wrPipe_reg <= 6'h00;
    end else begin
      rdPipe_reg <= {rdPipe_reg[6:0], rdGo};
      wrPipe_reg <= {wrPipe_reg[4:0], wrGo};
    end
  end
  // ------
  // assertions
  // ------
  k_toggle_a: assert property (!$past(rst) |-> kRise != $past(kRise))
    else $error("kRise did not alternate");
  echo_delay_a: assert property (!$past(rst) |-> echoTimingOut == $past(kRise))
    else $error("echo output not one edge behind kRise");
  rd_start_a: assert property ($fell(readPortSelectN) |-> kRise)
    else $error("read select fell off a K rise");
  wr_start_a: assert property ($fell(writePortSelectN) |-> kRise)
    else $error("write select fell off a K rise");
  rd_lat_dll_a: assert property (rdGo && dllOffStrapN |-> ##4 rdDataOe [*4])
    else $error("read burst not out three beats after request");
  rd_lat_legacy_a: assert property (rdGo && !dllOffStrapN |-> ##3 rdDataOe [*4])
    else $error("legacy read burst not out two beats after request");
  oe_window_a: assert property (rdDataOe |-> |rdPipe_reg[7:2])
    else $error("read bus driven outside a burst");
  oe_float_a: assert property ($fell(rdDataOe) |-> $past(kRise))
    else $error("read bus released off a positive clock rise");
  wr_beats_a: assert property (byteLaneEnableN != 2'h3 |-> |wrPipe_reg[4:1])
    else $error("byte lane enabled outside a write burst");
  cover property (rdGo);
  cover property (wrGo);
  cover property (rdGo && !dllOffStrapN);
  cover property ($fell(rdDataOe));
endmodule : spbs_props

// *** testbench.sv ***
// testbench: drives the host user side, scores read words against a memory model
// assumes host and device joined by spbs_if on one core_clk
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdReady;
  logic cmdWrite = 1'b0;
  logic [spbs_pkg::ADDR_W-1:0] cmdAddr = '0;
  logic [71:0] cmdWrData = '0;
  logic [7:0] cmdByteEnN = 8'hFF;
  logic dllOffStrapN = 1'b1;
  logic singleClock = 1'b0;
  logic rdValid;
  logic rdReady = 1'b0;
  logic [17:0] rdWord;
  logic singleClockMode;
  logic stall = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [71:0] mdl [int];
  logic [17:0] expQ [$];
  int used [$];
  spbs_if lnk ();
  spbs_device i_spbs_device (.core_clk(core_clk), .rst(rst), .link(lnk),
    .dllOffStrapN(dllOffStrapN), .singleClockMode(singleClockMode));
  spbs_host i_spbs_host (.core_clk(core_clk), .rst(rst), .link(lnk), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
    .cmdByteEnN(cmdByteEnN), .dllOffStrapN(dllOffStrapN), .singleClock(singleClock),
    .rdValid(rdValid), .rdReady(rdReady), .rdWord(rdWord));
  spbs_props i_spbs_props (.core_clk(core_clk), .rst(rst), .kRise(lnk.kRise),
    .readPortSelectN(lnk.readPortSelectN), .writePortSelectN(lnk.writePortSelectN),
    .addr(lnk.addr), .wrData(lnk.wrData), .byteLaneEnableN(lnk.byteLaneEnableN),
    .outClkStrapHigh(lnk.outClkStrapHigh), .rdData(lnk.rdData), .rdDataOe(lnk.rdDataOe),
    .echoTimingOut(lnk.echoTimingOut), .dllOffStrapN(dllOffStrapN));
  always #12.5 core_clk = ~core_clk;
  // random stalls on the read side keep the FIFO between empty and full
  always @(negedge core_clk) rdReady <= !stall && ($urandom_range(3) != 0);
  // ------
  // shared tasks
  // ------
  task automatic check(input string nm, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  function automatic logic [71:0] rnd72();
    return 72'({$urandom(), $urandom(), $urandom()});
  endfunction : rnd72
  // called at a falling edge, returns at the falling edge after acceptance
  task automatic send(input logic w, input logic [18:0] a, input logic [71:0] d,
                      input logic [7:0] m);
    int n;
    n = 0;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdWrData = d;
    cmdByteEnN = m;
    #1;
    while (cmdReady !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      #1;
      n++;
    end
    if (n >= 400) check("cmdReady wait", 72'h1, 72'h0);
    @(negedge core_clk);
  endtask : send
  task automatic wr(input logic [18:0] a, input logic [71:0] d, input logic [7:0] m);
    send(1'b1, a, d, m);
    if (!mdl.exists(a)) mdl[a] = 'x;
    for (int b = 0; b < 8; b++) if (!m[b]) mdl[a][b*9 +: 9] = d[b*9 +: 9];
  endtask : wr
  task automatic rd(input logic [18:0] a);
    send(1'b0, a, '0, 8'hFF);
    for (int k = 0; k < 4; k++) expQ.push_back(mdl[a][k*18 +: 18]);
  endtask : rd
  task automatic drain();
    int n;
    n = 0;
    cmdValid = 1'b0;
    while (expQ.size() != 0 && n < 600) begin
      @(negedge core_clk);
      n++;
    end
    check("words left", 72'h0, 72'(expQ.size()));
  endtask : drain
  // ------
  // scoreboard and watchdog
  // ------
  always @(posedge core_clk) begin
    if (!rst && rdValid === 1'b1 && rdReady === 1'b1) begin
      if (expQ.size() == 0) check("spare word", 72'h0, 72'h1);
      else check("rdWord", 72'(expQ.pop_front()), 72'(rdWord));
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    logic [18:0] a;
    void'($urandom(32'h94E2AC2F));
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 6; i++) begin
      a = 19'($urandom());
      used.push_back(int'(a));
      wr(a, rnd72(), 8'h00);
    end
    for (int i = 0; i < 6; i++) rd(19'(used[i]));
    drain();
    $display("full bursts done");
    // odd rounds read first, so the read must see the older data
    for (int i = 0; i < 8; i++) begin
      a = 19'(used[$urandom_range(5)]);
      if (i[0]) rd(a);
      wr(a, rnd72(), (i == 0) ? 8'hFF : 8'($urandom()));
      if (!i[0]) rd(a);
    end
    drain();
    $display("masked and forwarded done");
    stall = 1'b1;
    fork
      for (int i = 0; i < 6; i++) rd(19'(used[i]));
      begin
        repeat (100) @(negedge core_clk);
        check("rdValid held", 72'h1, 72'(rdValid));
        stall = 1'b0;
      end
    join
    drain();
    $display("fifo full and drain done");
    singleClock = 1'b1;
    dllOffStrapN = 1'b0;
    repeat (4) @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
    check("singleClockMode", 72'h1, 72'(singleClockMode));
    singleClock = 1'b0;
    repeat (4) @(negedge core_clk);
    check("singleClockMode", 72'h1, 72'(singleClockMode));
    for (int i = 0; i < 6; i++) begin
      rd(19'(used[i]));
      wr(19'(used[i]), rnd72(), 8'($urandom()));
    end
    for (int i = 0; i < 6; i++) rd(19'(used[i]));
    drain();
    $display("legacy mode done");
    stop_test();
  end
endmodule : testbench
